// *** hw/rlc_lane_regs.sv ***
// Lane configuration register slice of a serial-link repeater.
// Assumes a byte-wide register port from the management bus front end on
// mclk, and a global idle-threshold enable from the global control logic.
`timescale 1ns/1ns
// Behaviour
// - Bits 2:0 at 0x11 pick de-emphasis 0 to -12 dB, reset value 0x82.
// - Bits 3:2 at 0x12 pick the idle assert level, default 00.
// - Bits 1:0 at 0x12 pick the idle deassert level, default 00.
// - Idle levels apply only while global control bit 6 is set.
// - Detect code 00 keeps the input high impedance, 11 forces 50 ohm.
// - Detect code 01 tries every 12 ms, 50 times, then stops.
// - Detect code 10 tries every 12 ms until a receiver is found.
// - Automatic modes keep high impedance until a hit, then 50 ohm.
// - The 8-bit field at 0x16 sets equalizer gain, reset value 0x2F.
// - Bit 7 at 0x17 enables output short protection, reset 0xED.
// - Bit 6 at 0x17 selects first/second or third generation rate.
module rlc_lane_regs #(
  parameter int DET_INTERVAL_CYC = rlc_pkg::DET_INTERVAL_CYC
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic idle_threshold_enable,
  input wire logic far_present_pin,
  output logic [2:0] deemphasis_level,
  output logic [1:0] idle_assert_level,
  output logic [1:0] idle_deassert_level,
  output logic [1:0] far_receiver_detect,
  output logic [7:0] equalizer_gain,
  output logic short_protect_en,
  output logic gen12_rate_sel,
  output logic detect_attempt,
  output logic term_50ohm,
  output logic detect_found,
  output logic detect_gave_up
);

  // Write decode, shared by every register
  function automatic logic wr_hit(input logic wr,
                                  input logic [7:0] addr,
                                  input logic [7:0] off);
    wr_hit = wr && (addr == off);
  endfunction

  logic [7:0] deemph_q, deemph_d;
  logic [7:0] idle_q, idle_d;
  logic [7:0] detect_q, detect_d;
  logic [7:0] eq_q, eq_d;
  logic [7:0] rate_q, rate_d;
  logic [7:0] rdata_q, rdata_d;
  logic restart_q, restart_d;

  // Register writes; reserved 0x13/0x14 ignore writes
  always_comb
  begin
    deemph_d = deemph_q;
    idle_d = idle_q;
    detect_d = detect_q;
    eq_d = eq_q;
    rate_d = rate_q;
    if (wr_hit(reg_wr, reg_addr, rlc_pkg::OFF_CHA_DEEMPH))
      deemph_d = reg_wdata;
    if (wr_hit(reg_wr, reg_addr, rlc_pkg::OFF_CHA_IDLE))
      idle_d = reg_wdata;
    if (wr_hit(reg_wr, reg_addr, rlc_pkg::OFF_CHB_DETECT))
      detect_d = reg_wdata;
    if (wr_hit(reg_wr, reg_addr, rlc_pkg::OFF_CHB_EQ))
      eq_d = reg_wdata;
    if (wr_hit(reg_wr, reg_addr, rlc_pkg::OFF_CHB_RATE))
      rate_d = reg_wdata;
    // Any write to the detect register restarts the sequencer
    restart_d = wr_hit(reg_wr, reg_addr, rlc_pkg::OFF_CHB_DETECT);
  end

  // Read mux; data stays until the next read strobe
  always_comb
  begin
    rdata_d = rdata_q;
    if (reg_rd)
    begin
      case (reg_addr)
        rlc_pkg::OFF_CHA_DEEMPH: rdata_d = deemph_q;
        rlc_pkg::OFF_CHA_IDLE: rdata_d = idle_q;
        rlc_pkg::OFF_RSVD_13: rdata_d = rlc_pkg::RD_UNMAPPED;
        rlc_pkg::OFF_RSVD_14: rdata_d = rlc_pkg::RD_UNMAPPED;
        rlc_pkg::OFF_CHB_DETECT: rdata_d = detect_q;
        rlc_pkg::OFF_CHB_EQ: rdata_d = eq_q;
        rlc_pkg::OFF_CHB_RATE: rdata_d = rate_q;
        default: rdata_d = rlc_pkg::RD_UNMAPPED;
      endcase
    end
  end

  // Register storage
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      deemph_q <= rlc_pkg::RST_CHA_DEEMPH;
      idle_q <= rlc_pkg::RST_CHA_IDLE;
      detect_q <= rlc_pkg::RST_CHB_DETECT;
      eq_q <= rlc_pkg::RST_CHB_EQ;
      rate_q <= rlc_pkg::RST_CHB_RATE;
      rdata_q <= rlc_pkg::RD_UNMAPPED;
      restart_q <= 1'b0;
    end
    else
    begin
      deemph_q <= deemph_d;
      idle_q <= idle_d;
      detect_q <= detect_d;
      eq_q <= eq_d;
      rate_q <= rate_d;
      rdata_q <= rdata_d;
      restart_q <= restart_d;
    end
  end

  assign reg_rdata = rdata_q;

  // Direct field outputs, taken straight from the flops
  assign deemphasis_level = deemph_q[rlc_pkg::DEEMPH_LSB +: 3];
  assign far_receiver_detect = detect_q[rlc_pkg::DETECT_LSB +: 2];
  assign equalizer_gain = eq_q;
  assign short_protect_en = rate_q[rlc_pkg::RATE_SCP_BIT];
  assign gen12_rate_sel = rate_q[rlc_pkg::RATE_GEN12_BIT];

  // Gated idle levels; the analog side sees defaults until enabled
  logic [1:0] idle_as_q, idle_as_d;
  logic [1:0] idle_de_q, idle_de_d;

  always_comb
  begin
    if (idle_threshold_enable)
    begin
      idle_as_d = idle_q[rlc_pkg::IDLE_ASSERT_LSB +: 2];
      idle_de_d = idle_q[rlc_pkg::IDLE_DEASSERT_LSB +: 2];
    end
    else
    begin
      idle_as_d = rlc_pkg::IDLE_LEVEL_DEFAULT;
      idle_de_d = rlc_pkg::IDLE_LEVEL_DEFAULT;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      idle_as_q <= rlc_pkg::IDLE_LEVEL_DEFAULT;
      idle_de_q <= rlc_pkg::IDLE_LEVEL_DEFAULT;
    end
    else
    begin
      idle_as_q <= idle_as_d;
      idle_de_q <= idle_de_d;
    end
  end

  assign idle_assert_level = idle_as_q;
  assign idle_deassert_level = idle_de_q;

  // Far-end presence comes from the analog detector, not from mclk logic;
  // three flops, and a change only counts once the last two agree
  logic sync1_q, sync2_q, sync3_q;
  logic present_q, present_d;

  always_comb
  begin
    if (sync2_q == sync3_q)
      present_d = sync3_q;
    else
      present_d = present_q;
  end

  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      sync3_q <= 1'b0;
      present_q <= 1'b0;
    end
    else
    begin
      sync1_q <= far_present_pin;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      present_q <= present_d;
    end
  end

  // Detection sequencer; mode and restart arrive on the same edge
  rlc_detect_seq #(
    .INTERVAL_CYC(DET_INTERVAL_CYC)
  ) u_detect (
    .mclk(mclk),
    .reset_n(reset_n),
    .detect_mode(far_receiver_detect),
    .restart(restart_q),
    .far_present(present_q),
    .attempt(detect_attempt),
    .term_50ohm(term_50ohm),
    .det_found(detect_found),
    .det_gave_up(detect_gave_up)
  );

  // Field outputs follow a write one edge later; idle levels and forced termination two edges later
  deemph_write_a: assert property (
    @(posedge mclk) disable iff (!reset_n)
    reg_wr && reg_addr == 8'h11 |=> deemphasis_level == $past(reg_wdata[2:0]))
    else $error("de-emphasis field did not follow write");

  idle_assert_a: assert property (
    @(posedge mclk) disable iff (!reset_n)
    idle_threshold_enable && reg_wr && reg_addr == 8'h12
    ##1 idle_threshold_enable
    |=> idle_assert_level == $past(reg_wdata[3:2], 2))
    else $error("idle assert level wrong");

  idle_deassert_a: assert property (
    @(posedge mclk) disable iff (!reset_n)
    idle_threshold_enable && reg_wr && reg_addr == 8'h12
    ##1 idle_threshold_enable
    |=> idle_deassert_level == $past(reg_wdata[1:0], 2))
    else $error("idle deassert level wrong");

  idle_gate_a: assert property (
    @(posedge mclk) disable iff (!reset_n)
    !idle_threshold_enable |=> idle_assert_level == 2'h0 &&
    idle_deassert_level == 2'h0)
    else $error("idle levels applied while disabled");

  eq_write_a: assert property (
    @(posedge mclk) disable iff (!reset_n)
    reg_wr && reg_addr == 8'h16 |=> equalizer_gain == $past(reg_wdata))
    else $error("equalizer gain did not follow write");

  scp_write_a: assert property (
    @(posedge mclk) disable iff (!reset_n)
    reg_wr && reg_addr == 8'h17 |=> short_protect_en == $past(reg_wdata[7]))
    else $error("short protect bit did not follow write");

  rate_sel_a: assert property (
    @(posedge mclk) disable iff (!reset_n)
    reg_wr && reg_addr == 8'h17 |=> gen12_rate_sel == $past(reg_wdata[6]))
    else $error("rate select bit did not follow write");

  detect_restart_a: assert property (
    @(posedge mclk) disable iff (!reset_n)
    reg_wr && reg_addr == 8'h15 && reg_wdata[3:2] == 2'h3
    |=> ##1 term_50ohm)
    else $error("forced termination not applied");

  // Values after reset, checked without the reset disable on purpose; then equalizer readback
  deemph_reset_a: assert property (
    @(posedge mclk) !reset_n |=> deemph_q == 8'h82)
    else $error("de-emphasis register not at its reset value");

  eq_reset_a: assert property (
    @(posedge mclk) !reset_n |=> eq_q == 8'h2F)
    else $error("equalizer register not at its reset value");

  rate_reset_a: assert property (
    @(posedge mclk) !reset_n |=> rate_q == 8'hED)
    else $error("rate register not at its reset value");

  eq_readback_a: assert property (
    @(posedge mclk) disable iff (!reset_n)
    reg_rd && reg_addr == 8'h16 |=> reg_rdata == $past(eq_q))
    else $error("equalizer register read back wrong");

  // Sequencer outputs against the mode field; a restart edge is exempt
  forced_hold_a: assert property (
    @(posedge mclk) disable iff (!reset_n)
    far_receiver_detect == 2'h3 && !restart_q |-> term_50ohm)
    else $error("forced termination dropped");

  hiz_hold_a: assert property (
    @(posedge mclk) disable iff (!reset_n)
    far_receiver_detect == 2'h0 && !restart_q
    |-> !term_50ohm && !detect_attempt)
    else $error("high impedance mode probed or terminated");

  gave_up_mode_a: assert property (
    @(posedge mclk) disable iff (!reset_n)
    detect_gave_up && !restart_q |-> far_receiver_detect == 2'h1)
    else $error("gave up outside the limited mode");

  found_term_a: assert property (
    @(posedge mclk) disable iff (!reset_n)
    detect_found && !restart_q
    |-> term_50ohm && (far_receiver_detect == 2'h1 ||
    far_receiver_detect == 2'h2))
    else $error("receiver found without termination");

  auto_hiz_a: assert property (
    @(posedge mclk) disable iff (!reset_n)
    (far_receiver_detect == 2'h1 || far_receiver_detect == 2'h2) &&
    !restart_q && !detect_found |-> !term_50ohm)
    else $error("termination before a receiver was found");

  endless_keep_a: assert property (
    @(posedge mclk) disable iff (!reset_n)
    far_receiver_detect == 2'h2 && !restart_q |-> !detect_gave_up)
    else $error("endless mode stopped trying");

endmodule

// *** hw/rlc_pkg.sv ***
// Package for the lane configuration register slice of a serial repeater.
// Assumes a single 10 MHz clock; all register offsets are byte addresses.
package rlc_pkg;

  // Register offsets on the byte-wide management port
  localparam logic [7:0] OFF_CHA_DEEMPH = 8'h11;
  localparam logic [7:0] OFF_CHA_IDLE = 8'h12;
  localparam logic [7:0] OFF_RSVD_13 = 8'h13;
  localparam logic [7:0] OFF_RSVD_14 = 8'h14;
  localparam logic [7:0] OFF_CHB_DETECT = 8'h15;
  localparam logic [7:0] OFF_CHB_EQ = 8'h16;
  localparam logic [7:0] OFF_CHB_RATE = 8'h17;

  // Values after reset
  localparam logic [7:0] RST_CHA_DEEMPH = 8'h82;
  localparam logic [7:0] RST_CHA_IDLE = 8'h00;
  localparam logic [7:0] RST_CHB_DETECT = 8'h00;
  localparam logic [7:0] RST_CHB_EQ = 8'h2F;
  localparam logic [7:0] RST_CHB_RATE = 8'hED;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;

  // Field positions
  localparam int DEEMPH_LSB = 0;
  localparam int IDLE_DEASSERT_LSB = 0;
  localparam int IDLE_ASSERT_LSB = 2;
  localparam int DETECT_LSB = 2;
  localparam int RATE_SCP_BIT = 7;
  localparam int RATE_GEN12_BIT = 6;

  // Idle level used while the global enable is low (180 mV / 110 mV)
  localparam logic [1:0] IDLE_LEVEL_DEFAULT = 2'h0;

  // Far-end detection timing
  localparam int CLK_HZ = 10000000;
  localparam int DET_INTERVAL_MS = 12;
  localparam int DET_INTERVAL_CYC = (DET_INTERVAL_MS * (CLK_HZ / 1000));
  localparam int DET_CNT_W = 17;
  localparam logic [5:0] DET_MAX_TRIES = 6'h32;

  // Receiver-detect field codes
  typedef enum logic [1:0] {
    DETM_HIZ = 2'h0,
    DETM_AUTO_LIMITED = 2'h1,
    DETM_AUTO_ENDLESS = 2'h2,
    DETM_FORCED = 2'h3
  } rlc_detm_e;

  // Detection sequencer states
  typedef enum logic [2:0] {
    DET_HIZ = 3'h0,
    DET_WAIT = 3'h1,
    DET_FOUND = 3'h2,
    DET_GIVEUP = 3'h3,
    DET_FORCED = 3'h4
  } rlc_det_state_e;

endpackage

// *** hw/rlc_detect_seq.sv ***
// Far-end receiver detection sequencer for one channel.
// Assumes restart pulses together with a new mode value, and far_present
// already synchronised to mclk.
`timescale 1ns/1ns
module rlc_detect_seq #(
  parameter int INTERVAL_CYC = rlc_pkg::DET_INTERVAL_CYC
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [1:0] detect_mode,
  input wire logic restart,
  input wire logic far_present,
  output logic attempt,
  output logic term_50ohm,
  output logic det_found,
  output logic det_gave_up
);

  localparam logic [16:0] LAST = 17'(INTERVAL_CYC - 1);

  rlc_pkg::rlc_det_state_e state_q, state_d;
  logic [16:0] cnt_q, cnt_d;
  logic [5:0] tries_q, tries_d;
  logic attempt_q, attempt_d;
  logic term_q, term_d;
  logic tick;

  // Interval divider doubles as the attempt enable
  assign tick = (state_q == rlc_pkg::DET_WAIT) && (cnt_q == LAST);

  // Next state; a rewrite of the mode field restarts everything
  always_comb
  begin
    state_d = state_q;
    cnt_d = cnt_q;
    tries_d = tries_q;
    attempt_d = 1'b0;
    if (restart)
    begin
      cnt_d = 17'h00000;
      tries_d = 6'h00;
      case (detect_mode)
        rlc_pkg::DETM_HIZ: state_d = rlc_pkg::DET_HIZ;
        rlc_pkg::DETM_AUTO_LIMITED: state_d = rlc_pkg::DET_WAIT;
        rlc_pkg::DETM_AUTO_ENDLESS: state_d = rlc_pkg::DET_WAIT;
        rlc_pkg::DETM_FORCED: state_d = rlc_pkg::DET_FORCED;
        default: state_d = rlc_pkg::DET_HIZ;
      endcase
    end
    else
    begin
      case (state_q)
        rlc_pkg::DET_WAIT:
        begin
          if (tick)
          begin
            attempt_d = 1'b1;
            cnt_d = 17'h00000;
            tries_d = tries_q + 6'h01;
            if (far_present)
              state_d = rlc_pkg::DET_FOUND;
            else if (detect_mode == rlc_pkg::DETM_AUTO_LIMITED &&
                     tries_q == rlc_pkg::DET_MAX_TRIES - 6'h01)
              state_d = rlc_pkg::DET_GIVEUP;
            else
              state_d = rlc_pkg::DET_WAIT;
          end
          else
            cnt_d = cnt_q + 17'h00001;
        end
        default: state_d = state_q;
      endcase
    end
    // Termination only after a hit or when forced
    term_d = (state_d == rlc_pkg::DET_FOUND) ||
             (state_d == rlc_pkg::DET_FORCED);
  end

  // State registers
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      state_q <= rlc_pkg::DET_HIZ;
      cnt_q <= 17'h00000;
      tries_q <= 6'h00;
      attempt_q <= 1'b0;
      term_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      tries_q <= tries_d;
      attempt_q <= attempt_d;
      term_q <= term_d;
    end
  end

  assign attempt = attempt_q;
  assign term_50ohm = term_q;
  assign det_found = (state_q == rlc_pkg::DET_FOUND);
  assign det_gave_up = (state_q == rlc_pkg::DET_GIVEUP);

  // Checking helpers: cycles since the last attempt
  logic [16:0] gap_q;
  logic prev_q;
  always_ff @(posedge mclk)
  begin
    if (!reset_n || restart)
    begin
      gap_q <= 17'h00000;
      prev_q <= 1'b0;
    end
    else if (attempt_q)
    begin
      gap_q <= 17'h00001;
      prev_q <= 1'b1;
    end
    else
      gap_q <= gap_q + 17'h00001;
  end

  attempt_gap_a: assert property (
    @(posedge mclk) disable iff (!reset_n)
    attempt_q && prev_q && !restart |-> gap_q == 17'(INTERVAL_CYC))
    else $error("detect attempts not spaced by the interval");

  forced_term_a: assert property (
    @(posedge mclk) disable iff (!reset_n)
    restart && detect_mode == 2'h3 |=> term_q ##1 term_q)
    else $error("forced mode did not give termination");

  hiz_mode_a: assert property (
    @(posedge mclk) disable iff (!reset_n)
    restart && detect_mode == 2'h0 |=> !term_q && !attempt_q)
    else $error("high impedance mode drove termination");

  try_limit_a: assert property (
    @(posedge mclk) disable iff (!reset_n)
    state_q == rlc_pkg::DET_GIVEUP |-> tries_q == 6'h32)
    else $error("gave up at the wrong attempt count");

  stop_trying_a: assert property (
    @(posedge mclk) disable iff (!reset_n)
    state_q == rlc_pkg::DET_GIVEUP && $past(state_q) == rlc_pkg::DET_GIVEUP
    |-> !attempt_q && !term_q)
    else $error("attempt after giving up");

  hit_term_a: assert property (
    @(posedge mclk) disable iff (!reset_n)
    tick && far_present && !restart |=> term_q && attempt_q)
    else $error("detected receiver without termination");

  wait_hiz_a: assert property (
    @(posedge mclk) disable iff (!reset_n)
    state_q == rlc_pkg::DET_WAIT |-> !term_q)
    else $error("termination on before detection");

  endless_retry_a: assert property (
    @(posedge mclk) disable iff (!reset_n)
    state_q == rlc_pkg::DET_WAIT && detect_mode == 2'h2 && !restart
    |=> state_q != rlc_pkg::DET_GIVEUP)
    else $error("endless mode gave up");

endmodule

// *** verification/rlc_far_end.sv ***
// Far-end receiver model for the lane detection sequencer.
// Assumes detect_attempt is a one-cycle pulse on mclk and that the bench
// pulses rearm whenever it starts a new detection run.
`timescale 1ns/1ns
module rlc_far_end (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic rearm,
  input wire logic detect_attempt,
  input wire logic [7:0] appear_after,
  output logic far_present_pin
);
  logic [7:0] seen_q;

  // Probe counter, saturates so a long endless run cannot wrap
  always_ff @(posedge mclk)
  begin
    if (!reset_n || rearm)
      seen_q <= 8'h00;
    else if (detect_attempt && seen_q != 8'hFF)
      seen_q <= seen_q + 8'h01;
  end

  // Receiver appears after the chosen probe count; 0 keeps it absent
  assign far_present_pin = (appear_after != 8'h00) && (seen_q >= appear_after);
endmodule

// *** verification/testbench.sv ***
// Self-checking bench for the lane configuration register slice.
// Assumes the short detect interval of 20 cycles and a 10 MHz mclk.
`timescale 1ns/1ns
module testbench;
  localparam int IV = 20;
  logic mclk, reset_n, reg_wr, reg_rd, idle_threshold_enable;
  logic far_present_pin, rearm;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, appear_after, rd_v;
  logic [2:0] deemphasis_level;
  logic [1:0] idle_assert_level, idle_deassert_level, far_receiver_detect;
  logic [7:0] equalizer_gain;
  logic short_protect_en, gen12_rate_sel, detect_attempt, term_50ohm;
  logic detect_found, detect_gave_up;
  logic [7:0] offs [8] = '{8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h17,
                           8'h20};
  logic [7:0] rsts [8] = '{8'h82, 8'h00, 8'h00, 8'h00, 8'h00, 8'h2F, 8'hED,
                           8'h00};
  int error_cnt, checked, cyc, att_cnt, gap, last_att;

  rlc_lane_regs #(.DET_INTERVAL_CYC(IV)) dut (
    .mclk(mclk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .idle_threshold_enable(idle_threshold_enable),
    .far_present_pin(far_present_pin), .deemphasis_level(deemphasis_level),
    .idle_assert_level(idle_assert_level),
    .idle_deassert_level(idle_deassert_level),
    .far_receiver_detect(far_receiver_detect),
    .equalizer_gain(equalizer_gain), .short_protect_en(short_protect_en),
    .gen12_rate_sel(gen12_rate_sel), .detect_attempt(detect_attempt),
    .term_50ohm(term_50ohm), .detect_found(detect_found),
    .detect_gave_up(detect_gave_up));

  rlc_far_end far (
    .mclk(mclk), .reset_n(reset_n), .rearm(rearm),
    .detect_attempt(detect_attempt), .appear_after(appear_after),
    .far_present_pin(far_present_pin));

  // Clock source
  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  // Probe counting and interval capture; also the hang guard
  always @(posedge mclk)
  begin
    cyc++;
    if (detect_attempt === 1'b1)
    begin
      att_cnt++;
      gap = cyc - last_att;
      last_att = cyc;
    end
    if (cyc == 20000)
    begin
      error_cnt++;
      close_out();
    end
  end

  task automatic close_out();
    if (error_cnt == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge mclk);
    reg_wr = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(negedge mclk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge mclk);
    reg_rd = 1'b0;
    rd_v = reg_rdata;
  endtask

  // New detection run: rearm the far end, then rewrite the detect register
  task automatic set_det(input logic [7:0] d, input logic [7:0] app);
    @(negedge mclk);
    rearm = 1'b1;
    @(negedge mclk);
    rearm = 1'b0;
    // Set after the clear so no stale presence is shown
    appear_after = app;
    wr(rlc_pkg::OFF_CHB_DETECT, d);
    att_cnt = 0;
  endtask

  initial
  begin
    {reg_wr, reg_rd, idle_threshold_enable, rearm} = 4'h0;
    {reg_addr, reg_wdata, appear_after} = 24'h0;
    {error_cnt, checked, cyc, att_cnt, gap, last_att} = '0;
    reset_n = 1'b0;
    repeat (6) @(negedge mclk);
    reset_n = 1'b1;
    @(negedge mclk);
    check({5'h0, deemphasis_level}, 8'h02);
    check(equalizer_gain, 8'h2F);
    check({6'h0, short_protect_en, gen12_rate_sel}, 8'h03);
    check({7'h0, term_50ohm}, 8'h00);
    for (int i = 0; i < 8; i++)
    begin
      rd(offs[i]);
      check(rd_v, rsts[i]);
    end
    // Full-byte storage; reserved and unmapped places stay zero
    for (int i = 0; i < 8; i++)
      wr(offs[i], 8'hA5 ^ 8'(i));
    for (int i = 0; i < 8; i++)
    begin
      rd(offs[i]);
      check(rd_v, (i > 1 && i < 4) || i == 7 ? 8'h00 : 8'hA5 ^ 8'(i));
    end
    for (int c = 0; c < 8; c++)
    begin
      wr(rlc_pkg::OFF_CHA_DEEMPH, 8'h80 | 8'(c));
      check({5'h0, deemphasis_level}, 8'(c));
    end
    wr(rlc_pkg::OFF_CHB_RATE, 8'h40);
    check({6'h0, short_protect_en, gen12_rate_sel}, 8'h01);
    wr(rlc_pkg::OFF_CHB_RATE, 8'h80);
    check({6'h0, short_protect_en, gen12_rate_sel}, 8'h02);
    wr(rlc_pkg::OFF_CHB_EQ, 8'hFF);
    check(equalizer_gain, 8'hFF);
    // Idle levels programmed only with the global enable set
    idle_threshold_enable = 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      wr(rlc_pkg::OFF_CHA_IDLE, 8'((i << 2) | (3 - i)));
      @(negedge mclk);
      check({4'h0, idle_assert_level, idle_deassert_level},
            8'((i << 2) | (3 - i)));
    end
    idle_threshold_enable = 1'b0;
    @(negedge mclk);
    check({4'h0, idle_assert_level, idle_deassert_level}, 8'h00);
    rd(rlc_pkg::OFF_CHA_IDLE);
    check(rd_v, 8'h0C);
    // Forced termination, then high impedance with no probing
    set_det(8'h0C, 8'h00);
    @(negedge mclk);
    check({6'h0, far_receiver_detect}, 8'h03);
    check({7'h0, term_50ohm}, 8'h01);
    set_det(8'h00, 8'h00);
    repeat (100) @(negedge mclk);
    check({7'h0, term_50ohm}, 8'h00);
    check(8'(att_cnt), 8'h00);
    // Limited mode with no receiver: 50 probes, then give up
    set_det(8'h04, 8'h00);
    repeat (1100) @(negedge mclk);
    check(8'(att_cnt), 8'h32);
    check(8'(gap), 8'(IV));
    check({6'h0, detect_gave_up, term_50ohm}, 8'h02);
    // Rewrite in mid-run restarts the try count
    set_det(8'h04, 8'h00);
    repeat (10) @(posedge mclk iff detect_attempt === 1'b1);
    set_det(8'h04, 8'h00);
    repeat (1100) @(negedge mclk);
    check(8'(att_cnt), 8'h32);
    // Limited mode, receiver answers promptly at the third probe
    set_det(8'h04, 8'h02);
    repeat (100) @(negedge mclk);
    check(8'(att_cnt), 8'h03);
    check({6'h0, detect_found, term_50ohm}, 8'h03);
    // Endless mode, receiver answers late, well past 50 probes
    set_det(8'h08, 8'h3C);
    repeat (1150) @(negedge mclk);
    check({7'h0, att_cnt > 50}, 8'h01);
    check({7'h0, term_50ohm}, 8'h00);
    repeat (200) @(negedge mclk);
    check(8'(att_cnt), 8'h3D);
    check({5'h0, detect_found, term_50ohm, detect_gave_up}, 8'h06);
    // Reset in mid-run drops termination and restores the defaults
    reset_n = 1'b0;
    repeat (2) @(negedge mclk);
    reset_n = 1'b1;
    @(negedge mclk);
    check({5'h0, detect_found, term_50ohm, detect_gave_up}, 8'h00);
    check({5'h0, deemphasis_level}, 8'h02);
    check(equalizer_gain, 8'h2F);
    rd(rlc_pkg::OFF_CHB_DETECT);
    check(rd_v, 8'h00);
    close_out();
  end
endmodule
